// [bench/levr_espi_master.sv]
// Behavioural eSPI master that faces the block's pin side.
`timescale 1ns/1ps
module levr_espi_master (
	output logic espi_clk,
	output logic espi_cs_n,
	output logic espi_rst_n,
	output logic plt_rst_n,
	output logic [3:0] io_in
);
	initial begin
		espi_clk = 1'b0;
		espi_cs_n = 1'b1;
		espi_rst_n = 1'b1;
		plt_rst_n = 1'b1;
		io_in = 4'h0;
	end
	// The clock runs only inside a frame; released lines show the inverse.
	task automatic frame(input logic [3:0] d, input int n);
		espi_cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			io_in = d;
			#100 espi_clk = 1'b1;
			#100 espi_clk = 1'b0;
		end
		espi_cs_n = 1'b1;
		io_in = ~d;
	endtask : frame
	task automatic resets(input logic e, input logic p);
		espi_rst_n = e;
		plt_rst_n = p;
	endtask : resets
endmodule : levr_espi_master

// [bench/testbench.sv]
// Self-checking bench for the LPC error reporting block.
`timescale 1ns/1ps
`include "levr_params.svh"
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, lpc_addr, rd;
	logic espi_clk, espi_cs_n, espi_rst_n, plt_rst_n, err;
	logic [3:0] io_in, io_out, io_oe, tx_nibble, rx_data, vw_state;
	logic [3:0] lpc_sync, err_vw_sel, last_rx, last_tx;
	logic alert_n, alert_oe, cfg_alert_pin_en, tx_en, rx_valid;
	logic [1:0] cfg_io_mode;
	logic vw_fetch, vw_alert, plt_rst_out_n, lpc_start, lpc_tick;
	logic lpc_posted, lpc_write, lpc_mem, iochk_evt, sirq_smi, sirq_en;
	logic lpc_abandon, unsucc_cpl;
	int fails, total_checks, n_abt, n_unc, n_rx, bad_oe;
	levr_espi_master levr_espi_master_i (.espi_clk(espi_clk),
		.espi_cs_n(espi_cs_n), .espi_rst_n(espi_rst_n),
		.plt_rst_n(plt_rst_n), .io_in(io_in));
	levr_top levr_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.espi_clk(espi_clk), .espi_cs_n(espi_cs_n),
		.espi_rst_n(espi_rst_n), .plt_rst_n(plt_rst_n), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe), .alert_n(alert_n),
		.alert_oe(alert_oe), .cfg_alert_pin_en(cfg_alert_pin_en),
		.cfg_io_mode(cfg_io_mode), .tx_en(tx_en), .tx_nibble(tx_nibble),
		.rx_valid(rx_valid), .rx_data(rx_data), .vw_fetch(vw_fetch),
		.vw_state(vw_state), .vw_alert(vw_alert),
		.plt_rst_out_n(plt_rst_out_n), .lpc_start(lpc_start),
		.lpc_tick(lpc_tick), .lpc_sync(lpc_sync), .lpc_posted(lpc_posted),
		.lpc_write(lpc_write), .lpc_mem(lpc_mem), .lpc_addr(lpc_addr),
		.iochk_evt(iochk_evt), .err_vw_sel(err_vw_sel),
		.sirq_smi(sirq_smi), .sirq_en(sirq_en),
		.lpc_abandon(lpc_abandon), .unsucc_cpl(unsucc_cpl));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (lpc_abandon === 1'b1)
			n_abt++;
		if (unsucc_cpl === 1'b1)
			n_unc++;
		if (rx_valid === 1'b1)
			n_rx++;
		if (rx_valid === 1'b1)
			last_rx = rx_data;
		if (io_oe !== 4'h0)
			last_tx = io_out;
		if (cfg_io_mode == 2'd0 && (io_oe[0] | io_oe[2] | io_oe[3]) !== 1'b0)
			bad_oe++;
	end
	// -------------------------------------------------------------
	// Shared tasks
	// -------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rchk
	task automatic waitc(input int n);
		repeat (n) @(posedge pclk);
	endtask : waitc
	task automatic lpc(input logic p, input logic w, input logic m,
		input logic [31:0] a, input logic [11:0] s, input int n);
		@(posedge pclk);
		lpc_posted <= p;
		lpc_write <= w;
		lpc_mem <= m;
		lpc_addr <= a;
		lpc_start <= 1'b1;
		@(posedge pclk);
		lpc_start <= 1'b0;
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			lpc_tick <= 1'b1;
			lpc_sync <= s[4*i +: 4];
			@(posedge pclk);
			lpc_tick <= 1'b0;
		end
		waitc(3);
	endtask : lpc
	// -------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------
	task automatic t_reset();
		chk("sirq_en", 1'b0, sirq_en);
		chk("alert_oe", 1'b0, alert_oe);
		rchk("ctrl", `LEVR_CTRL_OFS, 32'h0);
		rchk("stat", `LEVR_STAT_OFS, 32'h3);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h0, rd);
		chk("pslverr", 1'b1, err);
		apb(1'b1, `LEVR_CTRL_OFS, 32'h1);
		waitc(1);
		chk("sirq_en", 1'b1, sirq_en);
	endtask : t_reset
	task automatic t_lpc();
		lpc(1'b0, 1'b0, 1'b0, 32'h1234abcd, 12'hfff, 3);
		chk("abandon", 1, n_abt);
		chk("unsucc", 1, n_unc);
		rchk("log_np", `LEVR_LOG_NP_OFS, 32'h1);
		rchk("log_p", `LEVR_LOG_P_OFS, 32'h0);
		rchk("attr", `LEVR_ATTR_OFS, 32'h0);
		rchk("addr0", `LEVR_ADDR0_OFS, 32'hcd);
		rchk("addr2", `LEVR_ADDR2_OFS, 32'h0);
		lpc(1'b1, 1'b1, 1'b1, 32'h89674523, 12'h0a5, 2);
		chk("abandon", 2, n_abt);
		chk("unsucc", 1, n_unc);
		rchk("log_p", `LEVR_LOG_P_OFS, 32'h2);
		rchk("log_np", `LEVR_LOG_NP_OFS, 32'h1);
		rchk("attr", `LEVR_ATTR_OFS, 32'h3);
		rchk("addr3", `LEVR_ADDR3_OFS, 32'h89);
		lpc(1'b0, 1'b1, 1'b0, 32'h00005678, 12'h0f6, 2);
		chk("unsucc", 2, n_unc);
		rchk("attr", `LEVR_ATTR_OFS, 32'h1);
		rchk("addr1", `LEVR_ADDR1_OFS, 32'h56);
		rchk("addr2", `LEVR_ADDR2_OFS, 32'h67);
		apb(1'b1, `LEVR_LOG_NP_OFS, 32'h1);
		apb(1'b1, `LEVR_LOG_P_OFS, 32'h2);
		rchk("log_np", `LEVR_LOG_NP_OFS, 32'h0);
		rchk("log_p", `LEVR_LOG_P_OFS, 32'h0);
	endtask : t_lpc
	task automatic t_vw();
		@(posedge pclk);
		cfg_alert_pin_en <= 1'b1;
		err_vw_sel <= 4'hf;
		iochk_evt <= 1'b1;
		@(posedge pclk);
		iochk_evt <= 1'b0;
		waitc(4);
		chk("vw_state", 4'hf, vw_state);
		chk("vw_alert", 1'b1, vw_alert);
		chk("alert_n", 1'b0, alert_n);
		chk("alert_oe", 1'b1, alert_oe);
		rchk("vw_err", `LEVR_VW_ERR_OFS, 32'h3);
		rchk("vw_evt", `LEVR_VW_EVT_OFS, 32'h3);
		@(posedge pclk);
		vw_fetch <= 1'b1;
		@(posedge pclk);
		vw_fetch <= 1'b0;
		waitc(3);
		chk("vw_alert", 1'b0, vw_alert);
		chk("alert_n", 1'b1, alert_n);
		apb(1'b1, `LEVR_VW_ERR_OFS, 32'h1);
		rchk("vw_err", `LEVR_VW_ERR_OFS, 32'h2);
		levr_espi_master_i.resets(1'b1, 1'b0);
		waitc(6);
		rchk("vw_evt", `LEVR_VW_EVT_OFS, 32'h0);
		rchk("vw_err", `LEVR_VW_ERR_OFS, 32'h2);
		levr_espi_master_i.resets(1'b0, 1'b1);
		waitc(6);
		chk("plt_out", 1'b0, plt_rst_out_n);
		rchk("vw_err", `LEVR_VW_ERR_OFS, 32'h0);
		levr_espi_master_i.resets(1'b1, 1'b1);
		waitc(6);
		chk("plt_out", 1'b1, plt_rst_out_n);
	endtask : t_vw
	task automatic t_smi();
		apb(1'b1, `LEVR_CTRL_OFS, 32'h0);
		sirq_smi <= 1'b1;
		waitc(6);
		chk("smi off", 1'b0, vw_state[2]);
		apb(1'b1, `LEVR_CTRL_OFS, 32'h1);
		waitc(6);
		chk("smi fwd", 1'b1, vw_state[2]);
		rchk("vw_evt", `LEVR_VW_EVT_OFS, 32'h0);
		levr_espi_master_i.resets(1'b1, 1'b0);
		waitc(6);
		chk("smi fwd", 1'b0, vw_state[2]);
		levr_espi_master_i.resets(1'b1, 1'b1);
		sirq_smi <= 1'b0;
		waitc(6);
	endtask : t_smi
	task automatic t_pins();
		logic [3:0] m;
		for (int i = 0; i < 3; i++) begin
			@(posedge pclk);
			cfg_io_mode <= i[1:0];
			tx_en <= 1'b1;
			n_rx = 0;
			last_tx = 4'h0;
			m = (i == 0) ? 4'h1 : (i == 1) ? 4'h3 : 4'hf;
			levr_espi_master_i.frame(4'h9, 2);
			waitc(6);
			chk("rx seen", 1, n_rx > 0);
			chk("rx_data", 4'h9 & m, last_rx & m);
			chk("io_out", (i == 0) ? 4'h2 : (4'h5 & m), last_tx);
		end
		chk("x1 oe", 0, bad_oe);
	endtask : t_pins
	task automatic t_idle();
		@(posedge pclk);
		cfg_alert_pin_en <= 1'b0;
		err_vw_sel <= 4'h4;
		waitc(4);
		chk("idle oe", 4'h2, io_oe);
		chk("idle out", 4'h2, io_out);
		chk("alert_oe", 1'b0, alert_oe);
		iochk_evt <= 1'b1;
		@(posedge pclk);
		iochk_evt <= 1'b0;
		waitc(4);
		chk("idle out", 4'h0, io_out);
		chk("alert_n", 1'b1, alert_n);
		rchk("vw_err", `LEVR_VW_ERR_OFS, 32'h0);
		rchk("vw_evt", `LEVR_VW_EVT_OFS, 32'h1);
	endtask : t_idle
	// -------------------------------------------------------------
	// Main sequence and watchdog
	// -------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{cfg_alert_pin_en, cfg_io_mode, tx_en} = '0;
		{vw_fetch, lpc_start, lpc_tick, lpc_sync, lpc_posted} = '0;
		{lpc_write, lpc_mem, lpc_addr, iochk_evt, err_vw_sel} = '0;
		sirq_smi = 1'b0;
		{fails, total_checks, n_abt, n_unc, n_rx, bad_oe} = '0;
		tx_nibble = 4'h5;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		waitc(4);
		t_reset();
		t_lpc();
		t_vw();
		t_smi();
		t_pins();
		t_idle();
		report_and_stop();
	end
	initial begin
		#500000;
		fails++;
		report_and_stop();
	end
endmodule : testbench

// [design/levr_params.svh]
// Constants for the LPC error logging and virtual wire reporting block.
//
// How it works
// - Serial interrupt forwarding stays off after reset until software enables it.
// - Enabling works the same before or after LPC interrupt sources are set up.
// - Four error wires: fatal, nonfatal, SMI, SCI, chosen by error-handling settings.
// - A posted error wire stays readable until software clears it by register.
// - eSPI reset also clears the fatal and nonfatal wires.
// - Platform or eSPI reset clears SMI and SCI; eSPI reset drives platform reset low.
// - Serial interrupt SMI is forwarded as seen, not recorded; platform reset clears it.
// - Each LPC error sets its own bit, non-posted and posted in separate logs.
// - Each error captures read or write and I/O or memory in an attribute register.
// - Each error captures the address; I/O loads two low bytes, memory all four.
// - Peripheral traffic goes to LPC, serial interrupts travel as virtual wires.
// - Every virtual wire is a single-bit state carried on the virtual wire channel.
// - eSPI configuration lives apart from internal registers, set only by eSPI commands.
// - Alert pin is driven only when enabled, else alert shows on line 1 when idle.
// - In x1 line 0 is input and line 1 output; in wider modes line 0 is LSB.
// - Lines 2 and 3 serve only quad mode, line 3 holding the MSB.
// - The eSPI reset is both eSPI power-on reset and host global reset.
// - No recognised sync within three LPC clocks means unclaimed; abandon the transfer.
// - A failed posted memory write never returns an unsuccessful completion.
`ifndef LEVR_PARAMS_SVH
`define LEVR_PARAMS_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define LEVR_CTRL_OFS 8'h00
`define LEVR_VW_ERR_OFS 8'h04
`define LEVR_VW_EVT_OFS 8'h08
`define LEVR_LOG_NP_OFS 8'h0c
`define LEVR_LOG_P_OFS 8'h10
`define LEVR_ATTR_OFS 8'h14
`define LEVR_ADDR0_OFS 8'h18
`define LEVR_ADDR1_OFS 8'h1c
`define LEVR_ADDR2_OFS 8'h20
`define LEVR_ADDR3_OFS 8'h24
`define LEVR_STAT_OFS 8'h28

// -----------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------
`define LEVR_LOG_UNC 0
`define LEVR_LOG_ABT 1
`define LEVR_LOG_CHK 2
`define LEVR_VW_FATAL 0
`define LEVR_VW_NONFATAL 1
`define LEVR_VW_SMI 2
`define LEVR_VW_SCI 3
`define LEVR_CTRL_RST 1'b0
`define LEVR_SYNC_RST 8'h20

// -----------------------------------------------------------------
// LPC sync codes and timing
// -----------------------------------------------------------------
`define LEVR_SYNC_READY 4'h0
`define LEVR_SYNC_SHORT 4'h5
`define LEVR_SYNC_LONG 4'h6
`define LEVR_SYNC_ERROR 4'ha
`define LEVR_NOSYNC_CLKS 2'd3

`endif

// [design/levr_pkg.sv]
// Types shared by the LPC error reporting block.
package levr_pkg;
	typedef enum logic [1:0] {LEVR_IDLE, LEVR_WAIT_SYNC, LEVR_LONG_WAIT}
		levr_state_t;
	typedef enum logic [1:0] {LEVR_X1, LEVR_X2, LEVR_X4} levr_mode_t;
endpackage : levr_pkg

// [design/levr_sync.sv]
// Two-flop synchroniser bank for inputs from outside the pclk domain.
`timescale 1ns/1ps
module levr_sync #(
	parameter int W = 8,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta[i] <= RST_VAL[i];
					q[i] <= RST_VAL[i];
				end else begin
					meta[i] <= d[i];
					q[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule : levr_sync

// [design/levr_top.sv]
// LPC error logging, error virtual wires and eSPI pin handling.
`timescale 1ns/1ps
`include "levr_params.svh"
module levr_top
	import levr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic espi_clk,
	input wire logic espi_cs_n,
	input wire logic espi_rst_n,
	input wire logic plt_rst_n,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe,
	output logic alert_n,
	output logic alert_oe,
	input wire logic cfg_alert_pin_en,
	input wire logic [1:0] cfg_io_mode,
	input wire logic tx_en,
	input wire logic [3:0] tx_nibble,
	output logic rx_valid,
	output logic [3:0] rx_data,
	input wire logic vw_fetch,
	output logic [3:0] vw_state,
	output logic vw_alert,
	output logic plt_rst_out_n,
	input wire logic lpc_start,
	input wire logic lpc_tick,
	input wire logic [3:0] lpc_sync,
	input wire logic lpc_posted,
	input wire logic lpc_write,
	input wire logic lpc_mem,
	input wire logic [31:0] lpc_addr,
	input wire logic iochk_evt,
	input wire logic [3:0] err_vw_sel,
	input wire logic sirq_smi,
	output logic sirq_en,
	output logic lpc_abandon,
	output logic unsucc_cpl
);
	// -----------------------------------------------------------------
	// Synchronisers and resets
	// -----------------------------------------------------------------
	logic [7:0] sync_q;
	logic erst_ok, plt_ok, cs_s, clk_s, clk_prev;
	logic [3:0] io_s;

	levr_sync #(.W(8), .RST_VAL(`LEVR_SYNC_RST)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({plt_rst_n, espi_rst_n, espi_cs_n, espi_clk, io_in}),
		.q(sync_q)
	);

	assign io_s = sync_q[3:0];
	assign clk_s = sync_q[4];
	assign cs_s = sync_q[5];
	assign erst_ok = sync_q[6];
	assign plt_ok = sync_q[7] & erst_ok;

	function automatic levr_mode_t mode_of(input logic [1:0] m);
		case (m)
			2'd1: mode_of = LEVR_X2;
			2'd2: mode_of = LEVR_X4;
			default: mode_of = LEVR_X1;
		endcase
	endfunction : mode_of

	// -----------------------------------------------------------------
	// LPC sync watcher
	// -----------------------------------------------------------------
	levr_state_t state, next_state;
	logic [1:0] nosync, next_nosync;
	logic hit_unc, hit_abt, hit_chk, hit_any, recog;
	logic next_abandon, next_unsucc;

	always_comb begin
		next_state = state;
		next_nosync = nosync;
		hit_unc = 1'b0;
		hit_abt = 1'b0;
		recog = (lpc_sync == `LEVR_SYNC_READY) ||
			(lpc_sync == `LEVR_SYNC_SHORT) ||
			(lpc_sync == `LEVR_SYNC_LONG) ||
			(lpc_sync == `LEVR_SYNC_ERROR);
		unique case (state)
			LEVR_IDLE: begin
				if (lpc_start) begin
					next_state = LEVR_WAIT_SYNC;
					next_nosync = 2'd0;
				end
			end
			LEVR_WAIT_SYNC: begin
				if (lpc_tick) begin
					if (lpc_sync == `LEVR_SYNC_READY) begin
						next_state = LEVR_IDLE;
					end else if (lpc_sync == `LEVR_SYNC_ERROR) begin
						hit_abt = 1'b1;
						next_state = LEVR_IDLE;
					end else if (recog) begin
						next_state = LEVR_LONG_WAIT;
					end else if (nosync == `LEVR_NOSYNC_CLKS - 2'd1) begin
						hit_unc = 1'b1;
						next_state = LEVR_IDLE;
					end else begin
						next_nosync = nosync + 2'd1;
					end
				end
			end
			LEVR_LONG_WAIT: begin
				if (lpc_tick) begin
					if (lpc_sync == `LEVR_SYNC_READY) begin
						next_state = LEVR_IDLE;
					end else if (lpc_sync == `LEVR_SYNC_ERROR) begin
						hit_abt = 1'b1;
						next_state = LEVR_IDLE;
					end else if (!recog) begin
						hit_unc = 1'b1;
						next_state = LEVR_IDLE;
					end
				end
			end
		endcase
		// IOCHK during a transfer is logged but does not end the cycle.
		hit_chk = iochk_evt && (state != LEVR_IDLE);
		hit_any = hit_unc | hit_abt | hit_chk;
		next_abandon = hit_unc | hit_abt;
		next_unsucc = (hit_unc | hit_abt) & ~lpc_posted;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= LEVR_IDLE;
			nosync <= 2'd0;
			lpc_abandon <= 1'b0;
			unsucc_cpl <= 1'b0;
		end else begin
			state <= next_state;
			nosync <= next_nosync;
			lpc_abandon <= next_abandon;
			unsucc_cpl <= next_unsucc;
		end
	end

	// -----------------------------------------------------------------
	// Logs, capture and virtual wires
	// -----------------------------------------------------------------
	logic [2:0] log_np, log_p, next_log_np, next_log_p, evbits;
	logic [1:0] attr, next_attr;
	logic [31:0] err_addr, next_err_addr;
	logic [3:0] vw_rec, next_vw_rec, vw_sent, next_vw_sent, next_vw_state;
	logic sirq_fwd, next_sirq_fwd, next_sirq_en;
	logic wr_acc;
	logic [3:0] set_vw;

	assign wr_acc = psel & penable & pwrite;

	always_comb begin
		next_log_np = log_np;
		next_log_p = log_p;
		next_attr = attr;
		next_err_addr = err_addr;
		next_vw_rec = vw_rec;
		next_vw_sent = vw_sent;
		next_sirq_en = sirq_en;
		evbits = {hit_chk, hit_abt, hit_unc};
		// Software clears first so that a same-cycle event wins.
		if (wr_acc) begin
			unique case (paddr)
				`LEVR_CTRL_OFS: next_sirq_en = pwdata[0];
				`LEVR_VW_ERR_OFS: next_vw_rec[1:0] = vw_rec[1:0] & ~pwdata[1:0];
				`LEVR_VW_EVT_OFS: next_vw_rec[3:2] = vw_rec[3:2] & ~pwdata[1:0];
				`LEVR_LOG_NP_OFS: next_log_np = log_np & ~pwdata[2:0];
				`LEVR_LOG_P_OFS: next_log_p = log_p & ~pwdata[2:0];
				default: ;
			endcase
		end
		if (hit_any) begin
			if (lpc_posted) begin
				next_log_p = next_log_p | evbits;
			end else begin
				next_log_np = next_log_np | evbits;
			end
			next_attr = {lpc_mem, lpc_write};
			next_err_addr[15:0] = lpc_addr[15:0];
			if (lpc_mem) begin
				next_err_addr[31:16] = lpc_addr[31:16];
			end
		end
		set_vw = (hit_any | iochk_evt) ? err_vw_sel : 4'h0;
		next_vw_rec = next_vw_rec | set_vw;
		if (!plt_ok) begin
			next_vw_rec[3:2] = 2'b00;
		end
		if (!erst_ok) begin
			next_vw_rec[1:0] = 2'b00;
		end
		// Serial IRQ SMI is a level copy only, never latched here.
		next_sirq_fwd = plt_ok & sirq_en & sirq_smi;
		next_vw_state = {vw_rec[3], vw_rec[2] | sirq_fwd, vw_rec[1:0]};
		if (!erst_ok) begin
			next_vw_sent = 4'h0;
		end else if (vw_fetch) begin
			next_vw_sent = vw_state;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			log_np <= 3'h0;
			log_p <= 3'h0;
			attr <= 2'h0;
			err_addr <= 32'h0;
			vw_rec <= 4'h0;
			vw_sent <= 4'h0;
			vw_state <= 4'h0;
			sirq_fwd <= 1'b0;
			sirq_en <= `LEVR_CTRL_RST;
		end else begin
			log_np <= next_log_np;
			log_p <= next_log_p;
			attr <= next_attr;
			err_addr <= next_err_addr;
			vw_rec <= next_vw_rec;
			vw_sent <= next_vw_sent;
			vw_state <= next_vw_state;
			sirq_fwd <= next_sirq_fwd;
			sirq_en <= next_sirq_en;
		end
	end

	assign vw_alert = |(vw_state ^ vw_sent);

	// -----------------------------------------------------------------
	// APB read path
	// -----------------------------------------------------------------
	logic [31:0] next_prdata;
	logic mapped;

	always_comb begin
		next_prdata = 32'h0;
		mapped = 1'b1;
		unique case (paddr)
			`LEVR_CTRL_OFS: next_prdata[0] = sirq_en;
			`LEVR_VW_ERR_OFS: next_prdata[1:0] = vw_rec[1:0];
			`LEVR_VW_EVT_OFS: next_prdata[1:0] = vw_rec[3:2];
			`LEVR_LOG_NP_OFS: next_prdata[2:0] = log_np;
			`LEVR_LOG_P_OFS: next_prdata[2:0] = log_p;
			`LEVR_ATTR_OFS: next_prdata[1:0] = attr;
			`LEVR_ADDR0_OFS: next_prdata[7:0] = err_addr[7:0];
			`LEVR_ADDR1_OFS: next_prdata[7:0] = err_addr[15:8];
			`LEVR_ADDR2_OFS: next_prdata[7:0] = err_addr[23:16];
			`LEVR_ADDR3_OFS: next_prdata[7:0] = err_addr[31:24];
			`LEVR_STAT_OFS: next_prdata[5:0] = {vw_state, plt_ok, erst_ok};
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable) begin
			prdata <= next_prdata;
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// -----------------------------------------------------------------
	// eSPI pins
	// -----------------------------------------------------------------
	logic [3:0] next_io_out, next_io_oe, next_rx_data;
	logic next_rx_valid, next_alert_n, next_alert_oe, next_plt_out;
	logic clk_rise, clk_fall;
	levr_mode_t mode;

	assign mode = mode_of(cfg_io_mode);
	assign clk_rise = clk_s & ~clk_prev;
	assign clk_fall = ~clk_s & clk_prev;

	always_comb begin
		next_io_out = io_out;
		next_io_oe = io_oe;
		next_rx_data = rx_data;
		next_rx_valid = 1'b0;
		next_alert_oe = cfg_alert_pin_en;
		next_alert_n = ~(vw_alert & cfg_alert_pin_en);
		next_plt_out = plt_ok;
		if (!erst_ok) begin
			next_io_oe = 4'h0;
			next_io_out = 4'h0;
		end else if (cs_s) begin
			// Idle bus: line 1 may carry the alert level.
			next_io_oe = {2'b00, ~cfg_alert_pin_en, 1'b0};
			next_io_out = {2'b00, ~vw_alert, 1'b0};
		end else begin
			if (clk_rise) begin
				next_rx_valid = 1'b1;
				unique case (mode)
					LEVR_X1: next_rx_data = {3'b000, io_s[0]};
					LEVR_X2: next_rx_data = {2'b00, io_s[1:0]};
					LEVR_X4: next_rx_data = io_s;
				endcase
			end
			if (clk_fall) begin
				unique case (mode)
					LEVR_X1: begin
						next_io_oe = {2'b00, tx_en, 1'b0};
						next_io_out = {2'b00, tx_nibble[0], 1'b0};
					end
					LEVR_X2: begin
						next_io_oe = {2'b00, tx_en, tx_en};
						next_io_out = {2'b00, tx_nibble[1:0]};
					end
					LEVR_X4: begin
						next_io_oe = {4{tx_en}};
						next_io_out = tx_nibble;
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_prev <= 1'b0;
			io_out <= 4'h0;
			io_oe <= 4'h0;
			rx_data <= 4'h0;
			rx_valid <= 1'b0;
			alert_n <= 1'b1;
			alert_oe <= 1'b0;
			plt_rst_out_n <= 1'b0;
		end else begin
			clk_prev <= clk_s;
			io_out <= next_io_out;
			io_oe <= next_io_oe;
			rx_data <= next_rx_data;
			rx_valid <= next_rx_valid;
			alert_n <= next_alert_n;
			alert_oe <= next_alert_oe;
			plt_rst_out_n <= next_plt_out;
		end
	end

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	nosync_abandon_a: assert property (
		(state == LEVR_WAIT_SYNC && lpc_tick && !recog && nosync == 2'd2)
		|=> lpc_abandon && state == LEVR_IDLE)
		else $error("unclaimed cycle not abandoned after three clocks");
	posted_cpl_a: assert property (
		(hit_unc || hit_abt) && lpc_posted |=> !unsucc_cpl)
		else $error("posted write returned unsuccessful completion");
	fatal_clear_a: assert property (
		!erst_ok |=> vw_rec[1:0] == 2'b00)
		else $error("fatal or nonfatal survived eSPI reset");
	event_clear_a: assert property (
		!plt_ok |=> vw_rec[3:2] == 2'b00 && !sirq_fwd)
		else $error("SMI or SCI survived platform reset");
	plt_follow_a: assert property (
		!erst_ok |=> !plt_rst_out_n)
		else $error("platform reset not forced by eSPI reset");
	sirq_gate_a: assert property (
		!sirq_en |=> !sirq_fwd)
		else $error("serial SMI forwarded while disabled");
	log_np_set_a: assert property (
		hit_unc && !lpc_posted |=> log_np[0] && $stable(log_p))
		else $error("non-posted unclaimed error not logged");
	io_addr_a: assert property (
		hit_any && !lpc_mem |=> err_addr[31:16] == $past(err_addr[31:16])
		&& err_addr[15:0] == $past(lpc_addr[15:0]))
		else $error("I/O error loaded wrong address bytes");
	alert_pin_a: assert property (
		!cfg_alert_pin_en ##1 !cfg_alert_pin_en |-> !alert_oe)
		else $error("alert pin driven while disabled");
	vw_hold_a: assert property (
		vw_rec[0] && !wr_acc && erst_ok |=> vw_rec[0])
		else $error("fatal wire cleared without software access");
endmodule : levr_top
